// *** common/vtml_defs.svh ***
/*
 * Object offsets, field positions, reset values and timing counts for the
 * velocity and torque monitor and limit block.
 * Assumes inclusion by bare name from any design or bench file.
 */
`ifndef VTML_DEFS_SVH
`define VTML_DEFS_SVH

// ----------------------------------------------------------------------
// Object indices (16-bit register addresses)
// ----------------------------------------------------------------------
`define VTML_SPEED_SENSOR_ACTUAL   16'h6069
`define VTML_SPEED_DEMAND         16'h606b
`define VTML_SPEED_ACTUAL         16'h606c
`define VTML_SPEED_COINCIDE_WIDTH 16'h606d
`define VTML_SPEED_COINCIDE_TIME  16'h606e
`define VTML_SPEED_THRESHOLD      16'h606f
`define VTML_SPEED_THRESHOLD_TIME 16'h6070
`define VTML_TORQUE_TARGET        16'h6071
`define VTML_TORQUE_MAXIMUM       16'h6072
`define VTML_TORQUE_DEMAND        16'h6074
`define VTML_TORQUE_ACTUAL        16'h6077
`define VTML_TORQUE_RAMP_SLOPE    16'h6087
`define VTML_SPEED_FEEDFORWARD    16'h60b1
`define VTML_TORQUE_FEEDFORWARD   16'h60b2
`define VTML_TORQUE_LIMIT_POS     16'h60e0
`define VTML_TORQUE_LIMIT_NEG     16'h60e1
`define VTML_SPEED_TARGET         16'h60ff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VTML_RST_TORQUE_MAXIMUM   16'h0bb8
`define VTML_RST_TORQUE_SLOPE     32'h0000_0064
`define VTML_RST_TORQUE_LIMIT     16'hffff

// ----------------------------------------------------------------------
// Statusword bits and timing
// ----------------------------------------------------------------------
`define VTML_SW_SPEED_COINCIDE    10
`define VTML_SW_SPEED_THRESHOLD   12
`define VTML_CLK_PERIOD_NS        10
`define VTML_TICK_MS              1
`define VTML_TICK_CYCLES          ((`VTML_TICK_MS * 1000000) / `VTML_CLK_PERIOD_NS)
`define VTML_SLOPE_TICK_NS        1000000000

`endif

// *** common/vtml_pkg.sv ***
/*
 * Types shared by the velocity and torque monitor and limit block.
 * Assumes the defs header is compiled alongside.
 */
package vtml_pkg;

    typedef enum logic [2:0] {
        VTML_MODE_PROFILE_VELOCITY,
        VTML_MODE_PROFILE_TORQUE,
        VTML_MODE_CSP,
        VTML_MODE_CSV,
        VTML_MODE_CST,
        VTML_MODE_OTHER
    } vtml_mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [31:0] wdata;
    } vtml_obj_req_t;

    typedef struct packed {
        logic signed [31:0] sensor_speed;
        logic signed [31:0] motor_speed;
        logic signed [31:0] traj_speed;
        logic signed [31:0] posctl_speed;
        logic signed [15:0] torque_out;
    } vtml_fbk_t;

    typedef struct packed {
        logic signed [31:0] speed_ref;
        logic signed [31:0] speed_ff;
        logic signed [15:0] torque_ff;
        logic signed [15:0] torque_ref;
        logic        [15:0] torque_lim_pos;
        logic        [15:0] torque_lim_neg;
    } vtml_ctl_t;

endpackage

// *** rtl/vtml_persist.sv ***
/*
 * Persistence qualifier: the flag rises once the condition has held for
 * the programmed number of millisecond ticks, and drops at once when the
 * condition fails.
 * Assumes one ref_clk domain and a one-cycle tick enable.
 */
`timescale 1ns/100ps
module vtml_persist #(
    parameter int TW = 16
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          tick,
    input  wire logic          cond,
    input  wire logic [TW-1:0] hold_ms,
    output logic               flag
);
    logic [TW-1:0] cnt_ff;
    logic          flag_ff;

    // Saturating counter; with a zero hold time the flag rises one cycle after the condition
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
        end else if (!cond) begin
            cnt_ff <= '0;
        end else if (tick && cnt_ff < hold_ms) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= cond && (cnt_ff >= hold_ms);
        end
    end

    assign flag = flag_ff && cond;
endmodule

// *** rtl/vtml_core.sv ***
/*
 * Velocity/torque object dictionary logic of a servo drive: references,
 * offsets, torque limits, demand and actual reports, statusword bits 10
 * and 12.
 * Assumes a single-cycle object port from the fieldbus side, feedback
 * values synchronous to ref_clk, and an externally supplied mode.
 */
//
// Behaviour
// [RULE_01] Bit 10 after speed gap held in window
// [RULE_02] Bit 12 after speed held above threshold
// [RULE_03] Positive limit is min of max and positive
// [RULE_04] Negative limit is min of max and negative
// [RULE_05] Profile torque output capped at maximum torque; code cuts at once on the positive side only, the negative side ramps
// [RULE_06] Sync torque mode adds offset to reference
// [RULE_07] Sync position/velocity use torque offset as feedforward
// [RULE_08] Sync position uses velocity offset as feedforward
// [RULE_09] Profile torque ramps output at programmed slope
// [RULE_10] Target torque is the torque reference input
// [RULE_11] Target velocity is velocity-mode speed target
// [RULE_12] Velocity demand reports speed loop input
// [RULE_13] Torque demand reports current torque output
// [RULE_14] Sensor and motor speeds read back signed
// [RULE_15] Host writes window and threshold settings unsigned
// [RULE_16] Flags clear and timers restart when condition fails
`timescale 1ns/100ps
`include "vtml_defs.svh"
module vtml_core
    import vtml_pkg::*;
#(
    parameter int TICK_CYCLES = `VTML_TICK_CYCLES,
    parameter int SLOPE_CYCLES = `VTML_SLOPE_TICK_NS / `VTML_CLK_PERIOD_NS
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire vtml_mode_t    mode,
    input  wire vtml_obj_req_t obj_req,
    input  wire vtml_fbk_t     fbk,
    output logic [31:0]        obj_rdata,
    output logic               obj_ack,
    output logic               obj_err,
    output vtml_ctl_t          ctl,
    output logic [15:0]        statusword
);
    // ------------------------------------------------------------------
    // Writable objects
    // ------------------------------------------------------------------
    logic        [15:0] win_ff;
    logic        [15:0] win_time_ff;
    logic        [15:0] thr_ff;
    logic        [15:0] thr_time_ff;
    logic signed [15:0] tq_target_ff;
    logic        [15:0] tq_max_ff;
    logic        [31:0] tq_slope_ff;
    logic signed [31:0] spd_off_ff;
    logic signed [15:0] tq_off_ff;
    logic        [15:0] tq_lim_pos_ff;
    logic        [15:0] tq_lim_neg_ff;
    logic signed [31:0] spd_target_ff;

    // ------------------------------------------------------------------
    // Derived state
    // ------------------------------------------------------------------
    logic signed [15:0] tq_ramp_ff;
    logic signed [15:0] tq_demand_ff;
    logic signed [31:0] spd_demand_ff;
    logic        [31:0] ms_cnt_ff;
    logic               ms_tick;
    logic        [31:0] sl_acc_ff;
    logic        [31:0] nxt_sl_acc;
    logic        [15:0] ramp_step;
    logic        [15:0] lim_pos;
    logic        [15:0] lim_neg;
    logic signed [17:0] tq_sum;
    logic signed [17:0] tq_clip;
    logic signed [15:0] tq_goal;
    logic signed [32:0] spd_gap;
    logic        [32:0] spd_gap_abs;
    logic               coin_cond;
    logic               thr_cond;
    logic               coin_flag;
    logic               thr_flag;
    logic               hit;
    logic        [31:0] rd_val;

    // ------------------------------------------------------------------
    // Object writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            win_ff        <= '0;
            win_time_ff   <= '0;
            thr_ff        <= '0;
            thr_time_ff   <= '0;
            tq_target_ff  <= '0;
            tq_max_ff     <= `VTML_RST_TORQUE_MAXIMUM;
            tq_slope_ff   <= `VTML_RST_TORQUE_SLOPE;
            spd_off_ff    <= '0;
            tq_off_ff     <= '0;
            tq_lim_pos_ff <= `VTML_RST_TORQUE_LIMIT;
            tq_lim_neg_ff <= `VTML_RST_TORQUE_LIMIT;
            spd_target_ff <= '0;
        end else if (obj_req.wr) begin
            if (obj_req.index == `VTML_SPEED_COINCIDE_WIDTH) begin
                win_ff <= obj_req.wdata[15:0]; // RULE_15
            end else if (obj_req.index == `VTML_SPEED_COINCIDE_TIME) begin
                win_time_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_SPEED_THRESHOLD) begin
                thr_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_SPEED_THRESHOLD_TIME) begin
                thr_time_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_TORQUE_TARGET) begin
                tq_target_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_TORQUE_MAXIMUM) begin
                tq_max_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_TORQUE_RAMP_SLOPE) begin
                tq_slope_ff <= obj_req.wdata;
            end else if (obj_req.index == `VTML_SPEED_FEEDFORWARD) begin
                spd_off_ff <= obj_req.wdata;
            end else if (obj_req.index == `VTML_TORQUE_FEEDFORWARD) begin
                tq_off_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_TORQUE_LIMIT_POS) begin
                tq_lim_pos_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_TORQUE_LIMIT_NEG) begin
                tq_lim_neg_ff <= obj_req.wdata[15:0];
            end else if (obj_req.index == `VTML_SPEED_TARGET) begin
                spd_target_ff <= obj_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Torque limits and reference path
    // ------------------------------------------------------------------
    assign lim_pos = (tq_max_ff < tq_lim_pos_ff) ? tq_max_ff : tq_lim_pos_ff; // RULE_03
    assign lim_neg = (tq_max_ff < tq_lim_neg_ff) ? tq_max_ff : tq_lim_neg_ff; // RULE_04

    always_comb begin
        if (mode == VTML_MODE_CST) begin
            tq_sum = 18'(tq_target_ff) + 18'(tq_off_ff); // RULE_06
        end else begin
            tq_sum = 18'(tq_target_ff); // RULE_10
        end
        // Clip to the effective limits; in profile torque the maximum
        // setting already bounds both limits
        if (tq_sum > $signed({2'b00, lim_pos})) begin
            tq_clip = $signed({2'b00, lim_pos}); // RULE_05
        end else if (tq_sum < -$signed({2'b00, lim_neg})) begin
            tq_clip = -$signed({2'b00, lim_neg});
        end else begin
            tq_clip = tq_sum;
        end
        if (tq_clip > 18'sd32767) begin
            tq_goal = 16'sh7fff;
        end else if (tq_clip < -18'sd32768) begin
            tq_goal = 16'sh8000;
        end else begin
            tq_goal = tq_clip[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Millisecond tick for the persistence timers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ms_cnt_ff <= '0;
        end else if (ms_cnt_ff == 32'(TICK_CYCLES - 1)) begin
            ms_cnt_ff <= '0;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
        end
    end
    assign ms_tick = (ms_cnt_ff == 32'(TICK_CYCLES - 1));

    // ------------------------------------------------------------------
    // Profile torque ramp
    // ------------------------------------------------------------------
    // Slope is 0.1 %/s: a fractional accumulator spreads the per-second
    // amount over cycles so slow slopes still move the output.
    always_comb begin
        nxt_sl_acc = sl_acc_ff + tq_slope_ff;
        ramp_step  = '0;
        if (nxt_sl_acc >= 32'(SLOPE_CYCLES) || nxt_sl_acc < sl_acc_ff) begin
            ramp_step  = 16'h0001;
            nxt_sl_acc = nxt_sl_acc - 32'(SLOPE_CYCLES);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sl_acc_ff <= '0;
        end else if (mode == VTML_MODE_PROFILE_TORQUE) begin
            sl_acc_ff <= nxt_sl_acc;
        end else begin
            sl_acc_ff <= '0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tq_ramp_ff <= '0;
        end else if (mode != VTML_MODE_PROFILE_TORQUE) begin
            tq_ramp_ff <= tq_goal;
        end else if (ramp_step != 16'h0000) begin
            // One 0.1 % step each time the accumulator rolls over
            if (tq_ramp_ff < tq_goal) begin
                tq_ramp_ff <= tq_ramp_ff + 16'sh0001; // RULE_09
            end else if (tq_ramp_ff > tq_goal) begin
                tq_ramp_ff <= tq_ramp_ff - 16'sh0001;
            end
        end else if (!lim_pos[15] && tq_ramp_ff > $signed({1'b0, lim_pos[14:0]})) begin
            // A lowered positive limit takes effect at once, not at ramp pace
            tq_ramp_ff <= tq_goal; // RULE_05
        end
    end

    // ------------------------------------------------------------------
    // Demand reports
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tq_demand_ff  <= '0;
            spd_demand_ff <= '0;
        end else begin
            tq_demand_ff <= tq_ramp_ff; // RULE_13
            if (mode == VTML_MODE_CSP) begin
                spd_demand_ff <= fbk.posctl_speed; // RULE_12
            end else if (mode == VTML_MODE_PROFILE_VELOCITY || mode == VTML_MODE_CSV) begin
                spd_demand_ff <= fbk.traj_speed;
            end else begin
                spd_demand_ff <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    always_comb begin
        ctl.speed_ref      = (mode == VTML_MODE_PROFILE_VELOCITY || mode == VTML_MODE_CSV)
                             ? spd_target_ff : 32'sh0; // RULE_11
        ctl.speed_ff       = (mode == VTML_MODE_CSP) ? spd_off_ff : 32'sh0; // RULE_08
        ctl.torque_ff      = (mode == VTML_MODE_CSP || mode == VTML_MODE_CSV)
                             ? tq_off_ff : 16'sh0000; // RULE_07
        ctl.torque_ref     = tq_ramp_ff;
        ctl.torque_lim_pos = lim_pos;
        ctl.torque_lim_neg = lim_neg;
    end

    // ------------------------------------------------------------------
    // Statusword speed flags
    // ------------------------------------------------------------------
    assign spd_gap     = 33'(spd_target_ff) - 33'(fbk.motor_speed);
    assign spd_gap_abs = spd_gap[32] ? -spd_gap : spd_gap;
    assign coin_cond   = spd_gap_abs <= {17'h0_0000, win_ff}; // RULE_01
    assign thr_cond    = fbk.motor_speed > $signed({16'h0000, thr_ff}); // RULE_02

    vtml_persist #(.TW(16)) u_coin (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (ms_tick),
        .cond    (coin_cond),
        .hold_ms (win_time_ff),
        .flag    (coin_flag)
    ); // RULE_16

    vtml_persist #(.TW(16)) u_thr (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (ms_tick),
        .cond    (thr_cond),
        .hold_ms (thr_time_ff),
        .flag    (thr_flag)
    );

    always_comb begin
        statusword = '0;
        statusword[`VTML_SW_SPEED_COINCIDE]  = coin_flag; // RULE_01
        statusword[`VTML_SW_SPEED_THRESHOLD] = thr_flag; // RULE_02
    end

    // ------------------------------------------------------------------
    // Object reads
    // ------------------------------------------------------------------
    always_comb begin
        hit    = 1'b1;
        rd_val = '0;
        if (obj_req.index == `VTML_SPEED_SENSOR_ACTUAL) begin
            rd_val = fbk.sensor_speed; // RULE_14
        end else if (obj_req.index == `VTML_SPEED_DEMAND) begin
            rd_val = spd_demand_ff;
        end else if (obj_req.index == `VTML_SPEED_ACTUAL) begin
            rd_val = fbk.motor_speed;
        end else if (obj_req.index == `VTML_SPEED_COINCIDE_WIDTH) begin
            rd_val = {16'h0, win_ff};
        end else if (obj_req.index == `VTML_SPEED_COINCIDE_TIME) begin
            rd_val = {16'h0, win_time_ff};
        end else if (obj_req.index == `VTML_SPEED_THRESHOLD) begin
            rd_val = {16'h0, thr_ff};
        end else if (obj_req.index == `VTML_SPEED_THRESHOLD_TIME) begin
            rd_val = {16'h0, thr_time_ff};
        end else if (obj_req.index == `VTML_TORQUE_TARGET) begin
            rd_val = 32'(tq_target_ff);
        end else if (obj_req.index == `VTML_TORQUE_MAXIMUM) begin
            rd_val = {16'h0000, tq_max_ff};
        end else if (obj_req.index == `VTML_TORQUE_DEMAND) begin
            rd_val = 32'(tq_demand_ff); // RULE_13
        end else if (obj_req.index == `VTML_TORQUE_ACTUAL) begin
            rd_val = 32'(fbk.torque_out);
        end else if (obj_req.index == `VTML_TORQUE_RAMP_SLOPE) begin
            rd_val = tq_slope_ff;
        end else if (obj_req.index == `VTML_SPEED_FEEDFORWARD) begin
            rd_val = spd_off_ff;
        end else if (obj_req.index == `VTML_TORQUE_FEEDFORWARD) begin
            rd_val = 32'(tq_off_ff);
        end else if (obj_req.index == `VTML_TORQUE_LIMIT_POS) begin
            rd_val = {16'h0000, tq_lim_pos_ff};
        end else if (obj_req.index == `VTML_TORQUE_LIMIT_NEG) begin
            rd_val = {16'h0000, tq_lim_neg_ff};
        end else if (obj_req.index == `VTML_SPEED_TARGET) begin
            rd_val = spd_target_ff;
        end else begin
            hit = 1'b0;
        end
    end

    // Answer one cycle after the request; bad writes flagged, not stored
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            obj_rdata <= '0;
            obj_ack   <= 1'b0;
            obj_err   <= 1'b0;
        end else begin
            obj_ack <= obj_req.rd || obj_req.wr;
            obj_err <= (obj_req.rd || obj_req.wr) && (!hit || (obj_req.wr
                       && (obj_req.index == `VTML_SPEED_SENSOR_ACTUAL
                        || obj_req.index == `VTML_SPEED_DEMAND
                        || obj_req.index == `VTML_SPEED_ACTUAL
                        || obj_req.index == `VTML_TORQUE_DEMAND
                        || obj_req.index == `VTML_TORQUE_ACTUAL)));
            if (obj_req.rd) begin
                obj_rdata <= hit ? rd_val : 32'h0;
            end
        end
    end
endmodule

// *** tb/vtml_core_chk.sv ***
/*
 * Port checker for the velocity/torque object block.
 * Assumes one ref_clk domain; shadows the written settings itself.
 */
`timescale 1ns/100ps
module vtml_core_chk
    import vtml_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          nrst,
    input wire vtml_mode_t    mode,
    input wire vtml_obj_req_t obj_req,
    input wire vtml_fbk_t     fbk,
    input wire logic [31:0]   obj_rdata,
    input wire logic          obj_ack,
    input wire logic          obj_err,
    input wire vtml_ctl_t     ctl,
    input wire logic [15:0]   statusword
);
    logic        [15:0] mx_ff, lp_ff, ln_ff, thr_ff, wid_ff;
    logic signed [31:0] tgt_ff;
    logic signed [32:0] gap;
    logic               take;
    assign take = obj_req.rd | obj_req.wr;
    assign gap = {tgt_ff[31], tgt_ff} - {fbk.motor_speed[31], fbk.motor_speed};
    // ----------------------------------------------------------------
    // Shadow of the settings that the flags and limits depend on
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mx_ff <= 16'h0bb8;
            lp_ff <= 16'hffff;
            ln_ff <= 16'hffff;
            thr_ff <= 16'h0;
            wid_ff <= 16'h0;
            tgt_ff <= 32'h0;
        end else if (obj_req.wr) begin
            case (obj_req.index)
                16'h6072: mx_ff <= obj_req.wdata[15:0];
                16'h60e0: lp_ff <= obj_req.wdata[15:0];
                16'h60e1: ln_ff <= obj_req.wdata[15:0];
                16'h606f: thr_ff <= obj_req.wdata[15:0];
                16'h606d: wid_ff <= obj_req.wdata[15:0];
                16'h60ff: tgt_ff <= obj_req.wdata;
                default: ;
            endcase
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    ack_after_req_a: assert property (take |=> obj_ack) else $error("ack missing");
    ack_no_req_a: assert property (!take |=> !obj_ack) else $error("ack without request");
    err_with_ack_a: assert property (obj_err |-> obj_ack) else $error("err without ack");
    pos_limit_min_a: assert property (ctl.torque_lim_pos == ((lp_ff < mx_ff) ? lp_ff : mx_ff))
        else $error("positive limit wrong");
    neg_limit_min_a: assert property (ctl.torque_lim_neg == ((ln_ff < mx_ff) ? ln_ff : mx_ff))
        else $error("negative limit wrong");
    status_spare_a: assert property ((statusword & 16'hebff) == 16'h0)
        else $error("spare status bit set");
    thresh_cause_a: assert property (statusword[12] |-> fbk.motor_speed > $signed({16'h0, thr_ff}))
        else $error("threshold flag without cause");
    coincide_cause_a: assert property (statusword[10] |->
        (gap <= $signed({17'h0, wid_ff})) && (gap >= -$signed({17'h0, wid_ff})))
        else $error("coincidence flag without cause");
    rdata_hold_a: assert property (!obj_req.rd |=> $stable(obj_rdata))
        else $error("read data moved");
    speed_ref_tgt_a: assert property ((mode == VTML_MODE_CSV) |-> ctl.speed_ref == tgt_ff)
        else $error("speed reference wrong");
    cover property ($rose(statusword[10]));
    cover property ($rose(statusword[12]));
    cover property (obj_err);
endmodule
bind vtml_core vtml_core_chk chk_i (.ref_clk(ref_clk), .nrst(nrst), .mode(mode),
    .obj_req(obj_req), .fbk(fbk), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_err(obj_err), .ctl(ctl), .statusword(statusword));

// *** tb/vtml_host.sv ***
/*
 * Host controller model issuing one-cycle object requests.
 * Assumes the block answers on the taking edge, one cycle after the request is driven.
 */
`timescale 1ns/100ps
module vtml_host
    import vtml_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [31:0] obj_rdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    output vtml_obj_req_t    obj_req
);
    initial obj_req = '0;
    task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic a);
        @(posedge ref_clk);
        obj_req <= '{wr: w, rd: !w, index: i, wdata: d};
        @(posedge ref_clk);
        obj_req <= '0;
        #1;
        r = obj_rdata;
        e = obj_err;
        a = obj_ack;
    endtask
endmodule

// *** tb/velocity_torque_monitor_limit_tb.sv ***
/*
 * Self-checking bench for the velocity/torque object block.
 * Assumes the host model drives all object traffic.
 */
`timescale 1ns/100ps
module velocity_torque_monitor_limit_tb
    import vtml_pkg::*;
;
    logic ref_clk, nrst;
    vtml_mode_t mode;
    vtml_fbk_t fbk;
    vtml_obj_req_t obj_req;
    vtml_ctl_t ctl;
    logic [31:0] obj_rdata;
    logic obj_ack, obj_err;
    logic [15:0] statusword;
    int error_cnt, compares, cyc_cnt;
    logic [15:0] didx [10] = '{16'h606d, 16'h606e, 16'h606f, 16'h6070, 16'h6071,
                               16'h6072, 16'h6087, 16'h60b1, 16'h60b2, 16'h60ff};
    logic [31:0] dval [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                               32'hbb8, 32'h64, 32'h0, 32'h0, 32'h0};
    vtml_core #(.TICK_CYCLES(10), .SLOPE_CYCLES(1000)) uut (.ref_clk(ref_clk), .nrst(nrst),
        .mode(mode), .obj_req(obj_req), .fbk(fbk), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .ctl(ctl), .statusword(statusword));
    vtml_host host (.ref_clk(ref_clk), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .obj_req(obj_req));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic er, ak;
        host.xfer(1'b1, i, d, r, er, ak);
        check($sformatf("write %h status", i), {30'h0, ak, er}, {30'h0, 1'b1, e});
    endtask
    task automatic rd(input logic [15:0] i, input logic [31:0] x, input logic e);
        logic [31:0] r;
        logic er, ak;
        host.xfer(1'b0, i, 32'h0, r, er, ak);
        check($sformatf("read %h status", i), {30'h0, ak, er}, {30'h0, 1'b1, e});
        if (!e) check($sformatf("object %h", i), r, x);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        nrst = 1'b0;
        mode = VTML_MODE_OTHER;
        fbk = '0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        check("pos limit", ctl.torque_lim_pos, 32'hbb8);
        for (int k = 0; k < 10; k++) rd(didx[k], dval[k], 1'b0);
        rd(16'h6073, 32'h0, 1'b1);
        wr(16'h6069, 32'h5, 1'b1);
        wr(16'h6072, 32'h64, 1'b0);
        check("neg limit", ctl.torque_lim_neg, 32'h64);
        wr(16'h60e0, 32'h32, 1'b0);
        wr(16'h60e1, 32'hc8, 1'b0);
        check("pos limit", ctl.torque_lim_pos, 32'h32);
        check("neg limit", ctl.torque_lim_neg, 32'h64);
        wr(16'h6072, 32'hbb8, 1'b0);
        wr(16'h60e0, 32'hffff, 1'b0);
        fbk.sensor_speed <= 32'hffff_fffb;
        fbk.motor_speed <= 32'h7;
        fbk.traj_speed <= 32'h11;
        fbk.posctl_speed <= 32'h22;
        mode <= VTML_MODE_CSV;
        rd(16'h6069, 32'hffff_fffb, 1'b0);
        rd(16'h606c, 32'h7, 1'b0);
        rd(16'h606b, 32'h11, 1'b0);
        wr(16'h60ff, 32'h3e8, 1'b0);
        check("speed ref", ctl.speed_ref, 32'h3e8);
        @(posedge ref_clk);
        mode <= VTML_MODE_CSP;
        rd(16'h606b, 32'h22, 1'b0);
        wr(16'h60b1, 32'h123, 1'b0);
        wr(16'h60b2, 32'hffce, 1'b0);
        check("speed ff", ctl.speed_ff, 32'h123);
        check("torque ff", ctl.torque_ff, 32'hffff_ffce);
        @(posedge ref_clk);
        mode <= VTML_MODE_CST;
        wr(16'h6071, 32'hc8, 1'b0);
        cyc(2);
        check("torque ref", ctl.torque_ref, 32'h96);
        rd(16'h6074, 32'h96, 1'b0);
        wr(16'h6071, 32'h0, 1'b0);
        cyc(2);
        rd(16'h6074, 32'hffff_ffce, 1'b0);
        wr(16'h60b2, 32'h0, 1'b0);
        wr(16'h6072, 32'h14, 1'b0);
        @(posedge ref_clk);
        mode <= VTML_MODE_PROFILE_TORQUE;
        wr(16'h6071, 32'h28, 1'b0);
        cyc(30);
        check("ramp midway", (ctl.torque_ref > 0 && ctl.torque_ref < 20), 32'h1);
        cyc(250);
        check("ramp end", ctl.torque_ref, 32'h14);
        wr(16'h606f, 32'h64, 1'b0);
        wr(16'h6070, 32'h3, 1'b0);
        fbk.motor_speed <= 32'h96;
        cyc(15);
        check("bit12 early", statusword[12], 32'h0);
        cyc(30);
        check("bit12 set", statusword[12], 32'h1);
        fbk.motor_speed <= 32'h64;
        cyc(1);
        check("bit12 drop", statusword[12], 32'h0);
        wr(16'h606d, 32'ha, 1'b0);
        wr(16'h606e, 32'h2, 1'b0);
        fbk.motor_speed <= 32'h3de;
        cyc(8);
        check("bit10 early", statusword[10], 32'h0);
        cyc(30);
        check("bit10 set", statusword[10], 32'h1);
        fbk.motor_speed <= 32'h3f3;
        cyc(1);
        check("bit10 drop", statusword[10], 32'h0);
        finish_test();
    end
endmodule
